// >>> src/sdi_cfg.svh
// Address map, field layout, reset values and bus codes of the sensor drive and identity block
`ifndef SDI_CFG_SVH
`define SDI_CFG_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define SDI_ADDR_W        12
`define SDI_IDX_W         10
`define SDI_DATA_W        32

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SDI_IDX_DRIVE3    10'h021
`define SDI_IDX_CONFIG    10'h030
`define SDI_IDX_MAKER     10'h07E
`define SDI_IDX_PART      10'h07F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SDI_SET_MSB       15
`define SDI_SET_LSB       11
`define SDI_CAL_MSB       10
`define SDI_CAL_LSB       6
`define SDI_OVR_BIT       0
`define SDI_AMPDIS_BIT    1
`define SDI_SET_LANE      1
`define SDI_CFG_LANE      0

// ----------------------------------------------------------------
// Reset values and response codes
// ----------------------------------------------------------------
`define SDI_DRIVE_RST     5'h00
`define SDI_BIT_RST       1'b0
`define SDI_RESP_OKAY     2'h0
`define SDI_RESP_SLVERR   2'h2
`define SDI_ZERO32        32'h00000000

`endif

// >>> src/sdi_pkg.sv
// Shared types of the sensor drive and identity block
package sdi_pkg;
  `include "sdi_cfg.svh"

  // Five-bit drive current code
  typedef logic [4:0] sdi_drive_t;

  // Events from the calibration engine
  typedef struct packed {
    logic       init_done;
    logic       corr_done;
    sdi_drive_t level;
  } sdi_cal_evt_t;

  // One complete register write from the bus port
  typedef struct packed {
    logic [`SDI_ADDR_W-1:0] addr;
    logic [`SDI_DATA_W-1:0] data;
    logic [3:0]             strb;
  } sdi_wr_req_t;
endpackage

// >>> src/sdi_axil_port.sv
// AXI4-Lite slave front end that turns bus traffic into register strobes
`timescale 1ns/1ps
module sdi_axil_port
  import sdi_pkg::*;
(
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Write address and data channels
  input  wire logic [`SDI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [`SDI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // Write response channel
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // Read channels
  input  wire logic [`SDI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [`SDI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Register side
  output sdi_wr_req_t                 wr_req,
  output logic                        wr_fire,
  input  wire logic                   wr_err,
  output logic [`SDI_ADDR_W-1:0]      rd_addr,
  input  wire logic [`SDI_DATA_W-1:0] rd_data,
  input  wire logic                   rd_err
);

  logic                   aw_held;
  logic                   w_held;
  logic                   ar_fire;
  logic [`SDI_ADDR_W-1:0] req_addr;
  logic [`SDI_DATA_W-1:0] req_data;
  logic [3:0]             req_strb;

  // -------------------------------------------------------------
  // Handshake terms
  // -------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_addr       = s_axi_araddr;

  // One driver for the whole request word
  assign wr_req = '{addr: req_addr, data: req_data, strb: req_strb};

  // Capture write address, either order with data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held  <= 1'b0;
      req_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held  <= 1'b1;
      req_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held  <= 1'b0;
    end
  end

  // Capture write data and strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held   <= 1'b0;
      req_data <= '0;
      req_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held   <= 1'b1;
      req_data <= s_axi_wdata;
      req_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held   <= 1'b0;
    end
  end

  // Write response after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SDI_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? `SDI_RESP_SLVERR : `SDI_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read answer registered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `SDI_ZERO32;
      s_axi_rresp  <= `SDI_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_err ? `SDI_RESP_SLVERR : `SDI_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> src/sdi_drive_regs.sv
// Channel 3 sensor drive register, drive override controls and identity registers
//
// Contract
// - The 5-bit drive setting sits in bits 15:11, resets to zero and is applied through settling and conversion.
// - The read-only field in bits 10:6 is loaded with the level from initial amplitude calibration, reset zero.
// - After each amplitude correction phase that field is refreshed, but only while correction disable is clear.
// - A read-only 16-bit maker code register answers at index 0x7E.
// - A read-only part code register answers at index 0x7F.
// - Setting the manual drive override bit disables automatic drive calibration in favour of the setting.
// - Setting the amplitude correction disable bit stops automatic amplitude correction.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module sdi_drive_regs
  import sdi_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'hA5C3, // Arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h0B17  // Arbitrary value
)(
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address and data
  input  wire logic [`SDI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [`SDI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [`SDI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [`SDI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Calibration engine
  input  wire sdi_cal_evt_t           cal_evt,
  output logic                        auto_cal_enable,
  output logic                        auto_amp_enable,
  // Sensor drive
  input  wire logic                   conv_active,
  output sdi_drive_t                  drive_out,
  output logic                        drive_is_manual
);

  // -------------------------------------------------------------
  // Storage and bus wiring
  // -------------------------------------------------------------
  sdi_drive_t             ch3_drive_current_setting;
  sdi_drive_t             ch3_calibrated_initial_drive;
  logic                   manual_drive_override;
  logic                   amplitude_correction_disable;
  sdi_wr_req_t            wr_req;
  logic                   wr_fire;
  logic                   wr_err;
  logic [`SDI_ADDR_W-1:0] rd_addr;
  logic [`SDI_DATA_W-1:0] rd_data;
  logic                   rd_err;
  sdi_drive_t             next_drive;

  // Word index match on a byte address
  function automatic logic reg_hit(input logic [`SDI_ADDR_W-1:0] a, input logic [`SDI_IDX_W-1:0] idx);
    reg_hit = (a[`SDI_ADDR_W-1:2] == idx);
  endfunction

  // Address belongs to the map
  function automatic logic reg_mapped(input logic [`SDI_ADDR_W-1:0] a);
    reg_mapped = reg_hit(a, `SDI_IDX_DRIVE3) || reg_hit(a, `SDI_IDX_CONFIG) ||
                 reg_hit(a, `SDI_IDX_MAKER) || reg_hit(a, `SDI_IDX_PART);
  endfunction

  // Bus front end
  sdi_axil_port u_port (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_req        (wr_req),
    .wr_fire       (wr_fire),
    .wr_err        (wr_err),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // -------------------------------------------------------------
  // Register writes
  // -------------------------------------------------------------

  // Unmapped writes answer with an error
  assign wr_err = !reg_mapped(wr_req.addr);

  // Drive setting, only its own bits are writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch3_drive_current_setting <= `SDI_DRIVE_RST;
    end else if (wr_fire && reg_hit(wr_req.addr, `SDI_IDX_DRIVE3) && wr_req.strb[`SDI_SET_LANE]) begin
      ch3_drive_current_setting <= wr_req.data[`SDI_SET_MSB:`SDI_SET_LSB];
    end
  end

  // Override and correction disable bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      manual_drive_override        <= `SDI_BIT_RST;
      amplitude_correction_disable <= `SDI_BIT_RST;
    end else if (wr_fire && reg_hit(wr_req.addr, `SDI_IDX_CONFIG) && wr_req.strb[`SDI_CFG_LANE]) begin
      manual_drive_override        <= wr_req.data[`SDI_OVR_BIT];
      amplitude_correction_disable <= wr_req.data[`SDI_AMPDIS_BIT];
    end
  end

  // -------------------------------------------------------------
  // Calibration capture
  // -------------------------------------------------------------

  // Initial calibration always loads; correction only when enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch3_calibrated_initial_drive <= `SDI_DRIVE_RST;
    end else if (cal_evt.init_done) begin
      ch3_calibrated_initial_drive <= cal_evt.level;
    end else if (cal_evt.corr_done && !amplitude_correction_disable) begin
      ch3_calibrated_initial_drive <= cal_evt.level;
    end
  end

  // Enables handed to the calibration engine
  assign auto_cal_enable = !manual_drive_override;
  assign auto_amp_enable = !amplitude_correction_disable;

  // -------------------------------------------------------------
  // Drive selection
  // -------------------------------------------------------------

  // Programmed drive only under override
  assign next_drive = manual_drive_override ? ch3_drive_current_setting
                                            : ch3_calibrated_initial_drive;

  // Frozen while settling and converting so the sensor sees one level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_out       <= `SDI_DRIVE_RST;
      drive_is_manual <= `SDI_BIT_RST;
    end else if (!conv_active) begin
      drive_out       <= next_drive;
      drive_is_manual <= manual_drive_override;
    end
  end

  // -------------------------------------------------------------
  // Register reads
  // -------------------------------------------------------------

  // Read mux, reserved and upper bits read zero
  always_comb begin
    rd_data = `SDI_ZERO32;
    rd_err  = 1'b0;
    if (reg_hit(rd_addr, `SDI_IDX_DRIVE3)) begin
      rd_data[`SDI_SET_MSB:`SDI_SET_LSB] = ch3_drive_current_setting;
      rd_data[`SDI_CAL_MSB:`SDI_CAL_LSB] = ch3_calibrated_initial_drive;
    end else if (reg_hit(rd_addr, `SDI_IDX_CONFIG)) begin
      rd_data[`SDI_OVR_BIT]    = manual_drive_override;
      rd_data[`SDI_AMPDIS_BIT] = amplitude_correction_disable;
    end else if (reg_hit(rd_addr, `SDI_IDX_MAKER)) begin
      rd_data[15:0] = MAKER_CODE;
    end else if (reg_hit(rd_addr, `SDI_IDX_PART)) begin
      rd_data[15:0] = PART_CODE;
    end else begin
      rd_err = 1'b1;
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------

  a_setting_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && reg_hit(wr_req.addr, `SDI_IDX_DRIVE3) && wr_req.strb[`SDI_SET_LANE]
    |=> ch3_drive_current_setting == $past(wr_req.data[`SDI_SET_MSB:`SDI_SET_LSB]))
    else $error("drive setting not stored");

  a_drive_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_active [*2] |-> $stable(drive_out))
    else $error("drive changed during conversion");

  a_override_source: assert property (@(posedge aclk) disable iff (!aresetn)
    !conv_active && manual_drive_override |=> drive_out == $past(ch3_drive_current_setting))
    else $error("override did not apply setting");

  a_calib_source: assert property (@(posedge aclk) disable iff (!aresetn)
    !conv_active && !manual_drive_override |=> drive_out == $past(ch3_calibrated_initial_drive))
    else $error("calibrated drive not applied");

  a_init_load: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_evt.init_done |=> ch3_calibrated_initial_drive == $past(cal_evt.level))
    else $error("initial calibration not captured");

  a_corr_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_evt.corr_done && !cal_evt.init_done |=>
    ch3_calibrated_initial_drive == ($past(amplitude_correction_disable) ?
      $past(ch3_calibrated_initial_drive) : $past(cal_evt.level)))
    else $error("correction refresh gating wrong");

  a_maker_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && reg_hit(s_axi_araddr, `SDI_IDX_MAKER)
    |=> s_axi_rvalid && s_axi_rdata == {16'h0000, MAKER_CODE} && s_axi_rresp == `SDI_RESP_OKAY)
    else $error("maker code read wrong");

  a_part_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && reg_hit(s_axi_araddr, `SDI_IDX_PART)
    |=> s_axi_rvalid && s_axi_rdata == {16'h0000, PART_CODE})
    else $error("part code read wrong");

  a_ro_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && !cal_evt.init_done && !cal_evt.corr_done |=> $stable(ch3_calibrated_initial_drive))
    else $error("write disturbed calibrated drive");

  a_amp_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && reg_hit(wr_req.addr, `SDI_IDX_CONFIG) && wr_req.strb[`SDI_CFG_LANE]
    |=> auto_amp_enable == !$past(wr_req.data[`SDI_AMPDIS_BIT]))
    else $error("correction enable not driven");

endmodule

// >>> tb/testbench.sv
// Self-checking bench for the sensor drive and identity register block
`timescale 1ns/1ps
`include "sdi_cfg.svh"
module testbench
  import sdi_pkg::*;
;
  // ----------------------------------------------------------------
  // Constants and signals
  // ----------------------------------------------------------------
  localparam logic [15:0] MAKER = 16'h3C5A; // Arbitrary value
  localparam logic [15:0] PART  = 16'h1D2E; // Arbitrary value
  localparam logic [11:0] A_DRV = {`SDI_IDX_DRIVE3, 2'b00};
  localparam logic [11:0] A_CFG = {`SDI_IDX_CONFIG, 2'b00};
  localparam logic [11:0] A_MKR = {`SDI_IDX_MAKER, 2'b00};
  localparam logic [11:0] A_PRT = {`SDI_IDX_PART, 2'b00};
  localparam logic [11:0] A_BAD = 12'h3F0;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
  logic         auto_cal_enable, auto_amp_enable, conv_active, drive_is_manual;
  sdi_cal_evt_t cal_evt;
  sdi_drive_t   drive_out;
  int           bad_count, compares;

  sdi_drive_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_sdi_drive_regs (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cal_evt(cal_evt), .auto_cal_enable(auto_cal_enable), .auto_amp_enable(auto_amp_enable),
    .conv_active(conv_active), .drive_out(drive_out), .drive_is_manual(drive_is_manual)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Clock at 4 ns period
  always #2 aclk = ~aclk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] drv(input logic [4:0] set, input logic [4:0] cal);
    return {16'h0000, set, cal, 6'h00};
  endfunction

  // Write with both halves offered together, bready held until the response
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    bit done = 0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        rsp = s_axi_bresp;
        done = 1;
        s_axi_bready <= 1'b0;
      end
    end
    @(posedge aclk);
  endtask

  // Read with rready held until rvalid is sampled
  task automatic axi_rd(input logic [11:0] a);
    bit done = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        done = 1;
        s_axi_rready <= 1'b0;
      end
    end
    @(posedge aclk);
  endtask

  // One-cycle calibration event pulse
  task automatic cal_pulse(input logic i, input logic c, input logic [4:0] lvl);
    cal_evt <= '{init_done: i, corr_done: c, level: lvl};
    @(posedge aclk);
    cal_evt <= '0;
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    axi_rd(A_DRV);
    check("drive reset", rd, 32'h00000000);
    axi_rd(A_CFG);
    check("config reset", rd, 32'h00000000);
    check("config read resp", {30'h0, rsp}, {30'h0, `SDI_RESP_OKAY});
    check("auto cal reset", {31'h0, auto_cal_enable}, 32'h1);
    check("auto amp reset", {31'h0, auto_amp_enable}, 32'h1);
    check("drive out reset", {27'h0, drive_out}, 32'h0);
  endtask

  task automatic t_ident();
    axi_rd(A_MKR);
    check("maker code", rd, {16'h0000, MAKER});
    axi_rd(A_PRT);
    check("part code", rd, {16'h0000, PART});
    axi_wr(A_MKR, 32'hFFFFFFFF, 4'hF);
    check("maker write resp", {30'h0, rsp}, {30'h0, `SDI_RESP_OKAY});
    axi_wr(A_PRT, 32'h00000000, 4'hF);
    axi_rd(A_MKR);
    check("maker after write", rd, {16'h0000, MAKER});
    axi_rd(A_PRT);
    check("part after write", rd, {16'h0000, PART});
  endtask

  task automatic t_setting();
    axi_wr(A_DRV, 32'hFFFFFFFF, 4'hF);
    check("drive write resp", {30'h0, rsp}, {30'h0, `SDI_RESP_OKAY});
    axi_rd(A_DRV);
    check("setting all ones", rd, drv(5'h1F, 5'h00));
    axi_wr(A_DRV, 32'h00009000, 4'h1);
    axi_rd(A_DRV);
    check("setting lane gated", rd, drv(5'h1F, 5'h00));
    axi_wr(A_DRV, 32'h00009000, 4'h2);
    axi_rd(A_DRV);
    check("setting eighteen", rd, drv(5'h12, 5'h00));
  endtask

  task automatic t_calib();
    cal_pulse(1'b1, 1'b0, 5'h0A);
    axi_rd(A_DRV);
    check("initial cal load", rd, drv(5'h12, 5'h0A));
    cal_pulse(1'b0, 1'b1, 5'h15);
    axi_rd(A_DRV);
    check("correction refresh", rd, drv(5'h12, 5'h15));
    axi_wr(A_CFG, 32'h00000002, 4'h1);
    check("auto amp off", {31'h0, auto_amp_enable}, 32'h0);
    cal_pulse(1'b0, 1'b1, 5'h03);
    axi_rd(A_DRV);
    check("correction blocked", rd, drv(5'h12, 5'h15));
    cal_pulse(1'b1, 1'b0, 5'h07);
    axi_rd(A_DRV);
    check("initial cal still loads", rd, drv(5'h12, 5'h07));
    axi_wr(A_CFG, 32'h00000000, 4'h1);
    check("auto amp on", {31'h0, auto_amp_enable}, 32'h1);
  endtask

  task automatic t_override();
    check("drive from cal", {27'h0, drive_out}, 32'h07);
    check("not manual", {31'h0, drive_is_manual}, 32'h0);
    axi_wr(A_CFG, 32'h00000001, 4'h1);
    check("auto cal off", {31'h0, auto_cal_enable}, 32'h0);
    check("drive from setting", {27'h0, drive_out}, 32'h12);
    check("manual flag", {31'h0, drive_is_manual}, 32'h1);
    conv_active <= 1'b1;
    @(posedge aclk);
    axi_wr(A_DRV, 32'h00002800, 4'h2);
    check("held in conversion", {27'h0, drive_out}, 32'h12);
    conv_active <= 1'b0;
    repeat (2) @(posedge aclk);
    check("new setting applied", {27'h0, drive_out}, 32'h05);
    cal_pulse(1'b0, 1'b1, 5'h1E);
    axi_rd(A_DRV);
    check("cal under override", rd, drv(5'h05, 5'h1E));
    check("override keeps setting", {27'h0, drive_out}, 32'h05);
    axi_wr(A_CFG, 32'h00000000, 4'h1);
    check("back to cal", {27'h0, drive_out}, 32'h1E);
  endtask

  task automatic t_unmapped();
    axi_rd(A_BAD);
    check("unmapped read resp", {30'h0, rsp}, {30'h0, `SDI_RESP_SLVERR});
    check("unmapped read data", rd, 32'h00000000);
    axi_wr(A_BAD, 32'hFFFFFFFF, 4'hF);
    check("unmapped write resp", {30'h0, rsp}, {30'h0, `SDI_RESP_SLVERR});
    axi_rd(A_DRV);
    check("drive untouched", rd, drv(5'h05, 5'h1E));
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    bad_count = 0;
    compares = 0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    cal_evt = '0;
    conv_active = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ident();
    t_setting();
    t_calib();
    t_override();
    t_unmapped();
    close_out();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    close_out();
  end
endmodule
